// ==== inc/uhed_defs.svh ====
// Register offsets, field positions and descriptor constants
`ifndef UHED_DEFS_SVH
`define UHED_DEFS_SVH
`define UHED_ADDR_W 8
`define UHED_OFS_CTRL 8'h00
`define UHED_OFS_VID 8'h04
`define UHED_OFS_PID 8'h08
`define UHED_OFS_DID 8'h0C
`define UHED_OFS_STATE 8'h10
`define UHED_OFS_DESC 8'h14
`define UHED_CTRL_LOAD_ROM 0
`define UHED_CTRL_COMMIT 1
`define UHED_CTRL_HS_DIS 2
`define UHED_CTRL_STR_EN 3
`define UHED_CTRL_PRST_LO 4
`define UHED_CTRL_LOADED 7
`define UHED_ST_CONF 8
`define UHED_ST_PWR_LO 9
`define UHED_ST_SUSP 12
`define UHED_ST_ATT 13
`define UHED_ST_FS 14
`define UHED_DESC_LEN 8'h12
`define UHED_DESC_TYPE 8'h01
`define UHED_DESC_BCD 16'h0200
`define UHED_DESC_CLASS 8'h09
`define UHED_DESC_SUB 8'h00
`define UHED_DESC_PROTO 8'h00
`define UHED_DESC_MPS 8'h40
`define UHED_DESC_NCFG 8'h01
`define UHED_STR_MFG 8'h01
`define UHED_STR_PROD 8'h02
`define UHED_STR_SER 8'h03
`define UHED_DESC_LAST 5'h11
`endif

// ==== inc/uhed_pkg.sv ====
// Types shared by the enumeration and descriptor logic
package uhed_pkg;
  typedef enum logic [2:0]
  {
    UHED_LOAD = 3'b001,
    UHED_DFLT = 3'b010,
    UHED_CONF = 3'b100
  } uhed_mode_t;

  typedef struct packed
  {
    logic [15:0] vid;
    logic [15:0] pid;
    logic [15:0] did;
  } uhed_ids_t;

  typedef struct packed
  {
    uhed_mode_t mode;
    uhed_ids_t ids;
    logic [6:0] addr;
    logic [2:0] pwr;
    logic [2:0] dsrst;
    logic str_en;
    logic hs_dis;
    logic susp;
    logic tt_flush;
    logic ack;
    logic [31:0] rdat;
    logic [4:0] idx;
    logic [2:0] rst_s;
    logic [2:0] sus_s;
  } uhed_state_t;

  typedef struct packed
  {
    logic [7:0] byte_val;
  } uhed_rom_state_t;
endpackage : uhed_pkg

// ==== verilog/uhed_desc_rom.sv ====
// Full-speed device descriptor byte source
`include "uhed_defs.svh"
module uhed_desc_rom
  import uhed_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [4:0] idx,
  input wire uhed_ids_t ids,
  input wire logic str_en,
  output logic [7:0] byte_out
);
  uhed_rom_state_t st_reg;
  uhed_rom_state_t st_next;

  // Multi-byte fields low byte first
  function automatic logic [7:0] desc_byte(input logic [4:0] i,
    input uhed_ids_t v, input logic s);
    logic [7:0] b;
    b = 8'h00;
    case (i)
      5'h00: b = `UHED_DESC_LEN;
      5'h01: b = `UHED_DESC_TYPE;
      5'h02: b = 8'(`UHED_DESC_BCD);
      5'h03: b = 8'(`UHED_DESC_BCD >> 8);
      5'h04: b = `UHED_DESC_CLASS;
      5'h05: b = `UHED_DESC_SUB;
      5'h06: b = `UHED_DESC_PROTO;
      5'h07: b = `UHED_DESC_MPS;
      5'h08: b = v.vid[7:0];
      5'h09: b = v.vid[15:8];
      5'h0A: b = v.pid[7:0];
      5'h0B: b = v.pid[15:8];
      5'h0C: b = v.did[7:0];
      5'h0D: b = v.did[15:8];
      5'h0E: b = s ? `UHED_STR_MFG : 8'h00;
      5'h0F: b = s ? `UHED_STR_PROD : 8'h00;
      5'h10: b = s ? `UHED_STR_SER : 8'h00;
      5'h11: b = `UHED_DESC_NCFG;
      default: b = 8'h00;
    endcase
    return b;
  endfunction : desc_byte

  always_comb
  begin
    st_next = st_reg;
    st_next.byte_val = desc_byte(idx, ids, str_en);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign byte_out = st_reg.byte_val;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Sampled reset in the antecedent: the byte is still cleared after release
  a_desc_len: assert property (rst_n && idx == 5'h00 |=>
    byte_out == 8'h12)
    else $error("descriptor length byte wrong");
  a_str_index: assert property (rst_n && idx == 5'h0F && str_en |=>
    byte_out == 8'h02)
    else $error("product string index wrong");
  a_str_off: assert property (rst_n && idx == 5'h10 && !str_en |=>
    byte_out == 8'h00)
    else $error("serial string index not zero");
endmodule : uhed_desc_rom

// ==== verilog/uhed_top.sv ====
// Hub upstream enumeration, bus reset handling and descriptor access
//
// Operation
// - Descriptor values from ROM or serial load
// - Stay detached until ROM load or commit
// - Never forward bus reset downstream
// - Bus reset sets device address zero
// - Bus reset returns hub to unconfigured
// - Bus reset clears port power bits
// - Bus reset flushes all TT buffers once attached
// - Bus reset wakes hub from suspend once attached
// - High speed disabled means full-speed attach
// - Device descriptor 18 bytes, type 01
// - Release number field reads 0200h
// - Hub class, subclass, protocol, packet 64
// - Vendor, product, device IDs as loaded
// - String indexes zero or 1,2,3
`include "uhed_defs.svh"
module uhed_top
  import uhed_pkg::*;
#(
  // Arbitrary neutral identifiers for the internal default set
  parameter logic [15:0] DEF_VID = 16'h1234,
  parameter logic [15:0] DEF_PID = 16'h5678,
  parameter logic [15:0] DEF_DID = 16'h0001,
  parameter logic DEF_HS_DIS = 1'b1,
  parameter logic DEF_STR_EN = 1'b0
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic usb_bus_reset,
  input wire logic usb_suspend,
  output logic attach_en,
  output logic full_speed_only,
  output logic [3:1] downstream_port_power,
  output logic [3:1] downstream_port_reset,
  output logic tt_flush,
  output logic [6:0] dev_addr,
  output logic configured
);
  uhed_state_t st_reg;
  uhed_state_t st_next;
  logic [7:0] desc_byte;
  logic req;
  logic wr;
  logic bus_rst_edge;
  logic susp_edge;
  logic loaded;

  // Byte-lane merge for the 16-bit identifier registers
  function automatic logic [15:0] merge16(input logic [15:0] old,
    input logic [31:0] d, input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0])
      r[7:0] = d[7:0];
    if (sel[1])
      r[15:8] = d[15:8];
    return r;
  endfunction : merge16

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a[7:2] == o[7:2];
  endfunction : hit

  assign req = wb_cyc_i && wb_stb_i && !st_reg.ack;
  // Write lands at the edge that sees ack, while the master still holds
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && st_reg.ack;
  // Edges compare the second and third synchroniser stages
  assign bus_rst_edge = st_reg.rst_s[1] && !st_reg.rst_s[2];
  assign susp_edge = st_reg.sus_s[1] && !st_reg.sus_s[2];
  assign loaded = st_reg.mode != UHED_LOAD;

  always_comb
  begin
    st_next = st_reg;
    st_next.rst_s = {st_reg.rst_s[1:0], usb_bus_reset};
    st_next.sus_s = {st_reg.sus_s[1:0], usb_suspend};
    st_next.ack = req;
    st_next.tt_flush = 1'b0;
    st_next.dsrst = 3'b000;
    // Read data holds until the next read
    if (req && !wb_we_i)
    begin
      st_next.rdat = 32'h0000_0000;
      if (hit(wb_adr_i, `UHED_OFS_CTRL))
      begin
        st_next.rdat[`UHED_CTRL_HS_DIS] = st_reg.hs_dis;
        st_next.rdat[`UHED_CTRL_STR_EN] = st_reg.str_en;
        st_next.rdat[`UHED_CTRL_LOADED] = loaded;
      end
      else if (hit(wb_adr_i, `UHED_OFS_VID))
        st_next.rdat[15:0] = st_reg.ids.vid;
      else if (hit(wb_adr_i, `UHED_OFS_PID))
        st_next.rdat[15:0] = st_reg.ids.pid;
      else if (hit(wb_adr_i, `UHED_OFS_DID))
        st_next.rdat[15:0] = st_reg.ids.did;
      else if (hit(wb_adr_i, `UHED_OFS_STATE))
      begin
        st_next.rdat[6:0] = st_reg.addr;
        st_next.rdat[`UHED_ST_CONF] = st_reg.mode == UHED_CONF;
        st_next.rdat[`UHED_ST_PWR_LO +: 3] = st_reg.pwr;
        st_next.rdat[`UHED_ST_SUSP] = st_reg.susp;
        st_next.rdat[`UHED_ST_ATT] = loaded;
        st_next.rdat[`UHED_ST_FS] = st_reg.hs_dis;
      end
      else if (hit(wb_adr_i, `UHED_OFS_DESC))
      begin
        st_next.rdat[4:0] = st_reg.idx;
        st_next.rdat[15:8] = desc_byte;
      end
    end
    if (wr)
    begin
      if (hit(wb_adr_i, `UHED_OFS_CTRL) && wb_sel_i[0])
      begin
        // Settings freeze once attached: the host already saw them
        if (!loaded)
        begin
          st_next.hs_dis = wb_dat_i[`UHED_CTRL_HS_DIS];
          st_next.str_en = wb_dat_i[`UHED_CTRL_STR_EN];
          if (wb_dat_i[`UHED_CTRL_LOAD_ROM])
          begin
            st_next.ids = '{vid: DEF_VID, pid: DEF_PID, did: DEF_DID};
            st_next.hs_dis = DEF_HS_DIS;
            st_next.str_en = DEF_STR_EN;
            st_next.mode = UHED_DFLT;
          end
          else if (wb_dat_i[`UHED_CTRL_COMMIT])
            st_next.mode = UHED_DFLT;
        end
        // Downstream resets come only from software
        st_next.dsrst = wb_dat_i[`UHED_CTRL_PRST_LO +: 3];
      end
      if (!loaded && hit(wb_adr_i, `UHED_OFS_VID))
        st_next.ids.vid = merge16(st_reg.ids.vid, wb_dat_i, wb_sel_i);
      if (!loaded && hit(wb_adr_i, `UHED_OFS_PID))
        st_next.ids.pid = merge16(st_reg.ids.pid, wb_dat_i, wb_sel_i);
      if (!loaded && hit(wb_adr_i, `UHED_OFS_DID))
        st_next.ids.did = merge16(st_reg.ids.did, wb_dat_i, wb_sel_i);
      if (loaded && hit(wb_adr_i, `UHED_OFS_STATE))
      begin
        if (wb_sel_i[0])
          st_next.addr = wb_dat_i[6:0];
        if (wb_sel_i[1])
        begin
          st_next.mode = wb_dat_i[`UHED_ST_CONF] ? UHED_CONF : UHED_DFLT;
          st_next.pwr = wb_dat_i[`UHED_ST_PWR_LO +: 3];
          if (!wb_dat_i[`UHED_ST_SUSP])
            st_next.susp = 1'b0;
        end
      end
      if (hit(wb_adr_i, `UHED_OFS_DESC) && wb_sel_i[0])
        st_next.idx = wb_dat_i[4:0];
    end
    // Suspend event wins over a software clear in the same cycle
    if (susp_edge)
      st_next.susp = 1'b1;
    // Bus reset overrides software writes to address, configuration, power and suspend in the same cycle
    if (bus_rst_edge && loaded)
    begin
      st_next.addr = 7'h00;
      st_next.mode = UHED_DFLT;
      st_next.pwr = 3'b000;
      st_next.tt_flush = 1'b1;
      st_next.susp = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
      st_reg.mode <= UHED_LOAD;
    end
    else
      st_reg <= st_next;
  end

  uhed_desc_rom u_rom
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .idx(st_reg.idx),
    .ids(st_reg.ids),
    .str_en(st_reg.str_en),
    .byte_out(desc_byte)
  );

  assign wb_ack_o = st_reg.ack;
  assign wb_dat_o = st_reg.rdat;
  assign attach_en = loaded;
  assign full_speed_only = st_reg.hs_dis;
  assign downstream_port_power = st_reg.pwr;
  assign downstream_port_reset = st_reg.dsrst;
  assign tt_flush = st_reg.tt_flush;
  assign dev_addr = st_reg.addr;
  assign configured = st_reg.mode == UHED_CONF;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_attach_gate: assert property ($rose(attach_en) |->
    $past(wr) && $past(wb_dat_i[1:0]) != 2'b00)
    else $error("attached without a configuration load");
  a_no_fwd_reset: assert property (bus_rst_edge && !wr |=>
    downstream_port_reset == 3'b000)
    else $error("bus reset reached downstream port");
  a_addr_zero: assert property (bus_rst_edge && loaded |=>
    dev_addr == 7'h00)
    else $error("address not cleared by bus reset");
  a_unconfig: assert property (bus_rst_edge && loaded |=>
    !configured ##1 (!configured || $past(wr)))
    else $error("configuration kept over bus reset");
  a_power_off: assert property (bus_rst_edge && loaded |=>
    downstream_port_power == 3'b000)
    else $error("port power kept over bus reset");
  a_tt_flush: assert property (tt_flush |->
    $past(bus_rst_edge) && !$past(tt_flush))
    else $error("flush without bus reset");
  a_wake: assert property (bus_rst_edge && loaded |=>
    !st_reg.susp)
    else $error("suspend kept over bus reset");
  a_fs_only: assert property ($stable(full_speed_only) || !attach_en
    || $past(!attach_en))
    else $error("speed mode changed while attached");
  a_rom_ids: assert property (wr && !loaded &&
    hit(wb_adr_i, `UHED_OFS_CTRL) && wb_sel_i[0] && wb_dat_i[0] |=>
    st_reg.ids.vid == DEF_VID && st_reg.ids.pid == DEF_PID &&
    st_reg.ids.did == DEF_DID)
    else $error("default identifiers not loaded");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  a_ack_next: assert property (req |=> wb_ack_o)
    else $error("request not acknowledged");
  a_rd_unmapped: assert property (req && !wb_we_i && wb_adr_i[7:2] > 6'h05
    |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped offset read not zero");

  a_prst_sw: assert property (downstream_port_reset != 3'b000 |->
    $past(wr))
    else $error("port reset without a software write");
  a_detached_idle: assert property (!attach_en |->
    !configured && dev_addr == 7'h00)
    else $error("address or configuration before attach");
  a_stay_attached: assert property (bus_rst_edge && loaded |=>
    attach_en)
    else $error("bus reset detached the hub");
  a_cfg_frozen: assert property (loaded && $past(loaded) |->
    $stable(st_reg.ids) && $stable(st_reg.str_en))
    else $error("identifiers changed while attached");
  a_addr_keep: assert property (!bus_rst_edge && !wr |=>
    $stable(dev_addr))
    else $error("address changed with no cause");
  a_conf_keep: assert property (!bus_rst_edge && !wr |=>
    $stable(configured))
    else $error("configuration changed with no cause");
  a_susp_set: assert property (susp_edge && !bus_rst_edge |=>
    st_reg.susp)
    else $error("suspend event lost");
  a_flush_once: assert property (tt_flush |=> !tt_flush)
    else $error("flush held two cycles");
  a_tt_attached: assert property (tt_flush |-> attach_en)
    else $error("flush while detached");
  a_rom_flags: assert property (wr && !loaded &&
    hit(wb_adr_i, `UHED_OFS_CTRL) && wb_sel_i[0] && wb_dat_i[0] |=>
    st_reg.hs_dis == DEF_HS_DIS && st_reg.str_en == DEF_STR_EN)
    else $error("default flags not loaded");

  // One set of checks per downstream port
  for (genvar p = 1; p <= 3; p++)
  begin : g_port
    a_port_off: assert property (bus_rst_edge && loaded |=>
      !downstream_port_power[p])
      else $error("port power bit kept over bus reset");
    a_port_quiet: assert property (bus_rst_edge && !wr |=>
      !downstream_port_reset[p])
      else $error("port reset follows a bus reset");
    a_port_keep: assert property (!bus_rst_edge && !wr |=>
      $stable(downstream_port_power[p]))
      else $error("port power changed with no cause");
  end

  c_attach: cover property ($rose(attach_en));
  c_bus_reset: cover property (bus_rst_edge && configured);
  c_reset_wake: cover property (bus_rst_edge && st_reg.susp);
  c_desc_read: cover property (wb_ack_o && st_reg.idx == `UHED_DESC_LAST);
  c_rom_load: cover property (wr && !loaded && wb_dat_i[0]);
endmodule : uhed_top

// ==== tb/uhed_host_model.sv ====
// Upstream host model: bus reset and suspend levels
module uhed_host_model
(
  input wire logic clk_sys,
  output logic usb_bus_reset,
  output logic usb_suspend
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    usb_bus_reset = 1'b0;
    usb_suspend = 1'b0;
  end

  // Held several cycles, as a host holds the line for a long reset
  task automatic send_reset;
    @(posedge clk_sys);
    usb_bus_reset <= 1'b1;
    repeat (4) @(posedge clk_sys);
    usb_bus_reset <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask : send_reset

  task automatic set_suspend(input logic v);
    @(posedge clk_sys);
    usb_suspend <= v;
    repeat (6) @(posedge clk_sys);
  endtask : set_suspend
endmodule : uhed_host_model

// ==== tb/test_uhed_top.sv ====
// Self-checking bench for the hub enumeration block
`include "uhed_defs.svh"
module test_uhed_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] ROM_VID = 16'h1234;
  localparam logic [15:0] ROM_PID = 16'h5678;
  localparam logic [15:0] ROM_DID = 16'h0001;
  logic clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic usb_bus_reset, usb_suspend, attach_en, full_speed_only;
  logic [3:1] downstream_port_power, downstream_port_reset;
  logic tt_flush, configured;
  logic [6:0] dev_addr;
  int bad_count = 0, n_checks = 0, cycles = 0, n_flush = 0, n_prst = 0;

  uhed_top #(.DEF_VID(ROM_VID), .DEF_PID(ROM_PID), .DEF_DID(ROM_DID),
    .DEF_HS_DIS(1'b1), .DEF_STR_EN(1'b0)) i_dut (.clk_sys(clk_sys),
    .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .usb_bus_reset(usb_bus_reset), .usb_suspend(usb_suspend),
    .attach_en(attach_en), .full_speed_only(full_speed_only),
    .downstream_port_power(downstream_port_power),
    .downstream_port_reset(downstream_port_reset),
    .tt_flush(tt_flush), .dev_addr(dev_addr), .configured(configured));

  uhed_host_model i_host (.clk_sys(clk_sys),
    .usb_bus_reset(usb_bus_reset), .usb_suspend(usb_suspend));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cycles++;
    if (tt_flush === 1'b1)
      n_flush++;
    if (rst_n === 1'b1 && downstream_port_reset !== 3'h0)
      n_prst++;
    if (cycles > 20000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    if (bad_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] e,
    input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : check

  // Request held until ack is sampled high, then one idle cycle
  task automatic wb_xfer(input logic we, input logic [7:0] adr,
    input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    check("ack cycles", 32'h0000_0002, 32'(n));
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_sys);
  endtask : wb_xfer

  task automatic check_desc(input logic [15:0] v, p, d, input logic s);
    logic [7:0] t [18];
    t = '{8'h12, 8'h01, 8'h00, 8'h02, 8'h09, 8'h00, 8'h00, 8'h40,
      v[7:0], v[15:8], p[7:0], p[15:8], d[7:0], d[15:8],
      {7'h0, s}, {6'h0, s, 1'b0}, {6'h0, s, s}, 8'h01};
    for (int i = 0; i < 18; i++)
    begin
      wb_xfer(1'b1, `UHED_OFS_DESC, 32'(i));
      wb_xfer(1'b0, `UHED_OFS_DESC, 32'h0);
      check("descriptor byte", {24'h0, t[i]}, {24'h0, q[15:8]});
    end
  endtask : check_desc

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
  endtask : do_reset

  task automatic test_commit;
    check("attach_en", 32'h0, {31'h0, attach_en});
    wb_xfer(1'b1, `UHED_OFS_VID, 32'h0000_beef);
    wb_xfer(1'b1, `UHED_OFS_PID, 32'h0000_cafe);
    wb_xfer(1'b1, `UHED_OFS_DID, 32'h0000_0321);
    check("attach_en", 32'h0, {31'h0, attach_en});
    wb_xfer(1'b1, `UHED_OFS_CTRL, 32'h0000_000e);
    wb_xfer(1'b1, `UHED_OFS_VID, 32'h0000_0000);
    check("attach_en", 32'h1, {31'h0, attach_en});
    check("fs_only", 32'h1, {31'h0, full_speed_only});
    check_desc(16'hbeef, 16'hcafe, 16'h0321, 1'b1);
  endtask : test_commit

  task automatic test_bus_reset;
    int f0, p0;
    wb_xfer(1'b1, `UHED_OFS_STATE, 32'h0000_0f2a);
    wb_xfer(1'b1, `UHED_OFS_CTRL, 32'h0000_0070);
    check("dev_addr", 32'h2a, {25'h0, dev_addr});
    check("power", 32'h7, {29'h0, downstream_port_power});
    check("configured", 32'h1, {31'h0, configured});
    i_host.set_suspend(1'b1);
    i_host.set_suspend(1'b0);
    wb_xfer(1'b0, `UHED_OFS_STATE, 32'h0);
    check("suspended", 32'h1, {31'h0, q[12]});
    check("port reset count", 32'h1, 32'(n_prst));
    f0 = n_flush;
    p0 = n_prst;
    i_host.send_reset();
    check("port reset", 32'(p0), 32'(n_prst));
    check("dev_addr", 32'h0, {25'h0, dev_addr});
    check("configured", 32'h0, {31'h0, configured});
    check("power", 32'h0, {29'h0, downstream_port_power});
    check("tt_flush", 32'(f0 + 1), 32'(n_flush));
    wb_xfer(1'b0, `UHED_OFS_STATE, 32'h0);
    check("suspended", 32'h0, {31'h0, q[12]});
    check("attached", 32'h1, {31'h0, q[13]});
    check("fs flag", 32'h1, {31'h0, q[14]});
  endtask : test_bus_reset

  task automatic test_rom;
    do_reset();
    check("attach_en", 32'h0, {31'h0, attach_en});
    wb_xfer(1'b1, `UHED_OFS_CTRL, 32'h0000_0003);
    check("attach_en", 32'h1, {31'h0, attach_en});
    check("fs_only", 32'h1, {31'h0, full_speed_only});
    wb_xfer(1'b0, `UHED_OFS_CTRL, 32'h0);
    check("str_en", 32'h0, {31'h0, q[3]});
    check("loaded", 32'h1, {31'h0, q[7]});
    check_desc(ROM_VID, ROM_PID, ROM_DID, 1'b0);
  endtask : test_rom

  initial
  begin
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    do_reset();
    test_commit();
    test_bus_reset();
    test_rom();
    give_verdict();
  end
endmodule : test_uhed_top
